// *** dcobj_pkg.sv ***
// constants shared by the drive control object block: object indices,
// subindices, reset values, bit positions and the power state encoding.
// assumes a single controller clock; indices are 16 bits, subindices 8 bits.
package dcobj_pkg;

    ////////////////////////////////////////////////////////////////////////
    // object indices and subindices
    localparam logic [15:0] IDX_COND    = 16'h4014;
    localparam logic [15:0] IDX_BALLAST = 16'h4021;
    localparam logic [15:0] IDX_BOOT    = 16'h4042;
    localparam logic [15:0] IDX_ERR     = 16'h603f;
    localparam logic [15:0] IDX_CMD     = 16'h6040;
    localparam logic [15:0] IDX_STAT    = 16'h6041;
    localparam logic [7:0]  SUB_0       = 8'h00;
    localparam logic [7:0]  SUB_1       = 8'h01;
    localparam logic [7:0]  SUB_2       = 8'h02;
    localparam logic [7:0]  SUB_3       = 8'h03;
    localparam logic [7:0]  SUB_4       = 8'h04;
    localparam logic [7:0]  SUB_5       = 8'h05;
    localparam logic [7:0]  COND_COUNT  = 8'h05;
    localparam logic [7:0]  BAL_COUNT   = 8'h03;
    localparam logic [7:0]  BOOT_COUNT  = 8'h03;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [31:0] BAL_SET_RST  = 32'h00000001;
    localparam logic [31:0] BAL_THR_RST  = 32'h0000c019;
    localparam logic [31:0] BAL_HYST_RST = 32'h000001f4;
    localparam logic [15:0] CMD_RST      = 16'h0000;
    localparam logic [15:0] ERR_RST      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BAL_EN_BIT      = 0;
    localparam int CMD_SWITCH_ON   = 0;
    localparam int CMD_VOLTAGE     = 1;
    localparam int CMD_QUICK_N     = 2;
    localparam int CMD_RUN_PERMIT  = 3;
    localparam int CMD_MODE_LO     = 4;
    localparam int CMD_MODE_HI     = 6;
    localparam int CMD_FAULT_CLEAR = 7;
    localparam int CMD_HALT        = 8;
    localparam int ST_READY        = 0;
    localparam int ST_SWITCHED_ON  = 1;
    localparam int ST_RUN          = 2;
    localparam int ST_FAULT        = 3;
    localparam int ST_VOLTAGE      = 4;
    localparam int ST_QUICK_N      = 5;
    localparam int ST_ON_DISABLED  = 6;
    localparam int ST_WARN         = 7;
    localparam int ST_REMOTE       = 9;

    ////////////////////////////////////////////////////////////////////////
    // operating modes in which halt acts
    localparam logic [7:0] MODE_PROF_POS  = 8'h01;
    localparam logic [7:0] MODE_VELOCITY  = 8'h02;
    localparam logic [7:0] MODE_PROF_VEL  = 8'h03;
    localparam logic [7:0] MODE_PROF_TORQ = 8'h04;
    localparam logic [7:0] MODE_INTERP    = 8'h07;

    // power state machine states
    typedef enum logic [2:0] {
        PST_NOT_READY,
        PST_ON_DISABLED,
        PST_READY,
        PST_SWITCHED_ON,
        PST_RUN,
        PST_QUICK_STOP,
        PST_FAULT_REACT,
        PST_FAULT
    } dcobj_pst_e;

endpackage : dcobj_pkg

// *** dcobj_drive_objects.sv ***
// drive control objects: object access port, ballast control, error code
// and command word driving the power state machine.
// assumes measurements, error log and mode come from logic on the same clock.
// What this block does
// (R1) supply, logic voltage and board temperature readable only; entries four, five reserved
// (R2) ballast settings bit 0 enables the ballast circuit, default on
// (R3) read/write 32-bit ballast switching threshold in mV, default 0xc019
// (R4) read/write hysteresis around the threshold in mV, default 0x1f4
// (R5) ballast on above threshold, off only below threshold minus hysteresis
// (R6) boot version: main number in upper half, minor in lower half
// (R7) boot fieldbus entry uses the fieldbus module availability bit layout
// (R8) error code shows low 16 bits of newest error log entry, resets zero
// (R9) fault clear at command bit seven returns the error code to zero
// (R10) 16-bit command word, read/write, reset zero, drives power state machine
// (R11) switch-on bit at one requests the switched-on state
// (R12) enable-voltage bit at one requests the voltage-enabled state
// (R13) quick-halt bit at zero requests the quick stop state
// (R14) run-permit bit at one requests the operation-enabled state
// (R15) fault clear resets an error or warning where that is allowed
// (R16) halt bit stops motion only in the five listed modes
// (R17) status quick stop bit reads zero while in quick stop
module dcobj_drive_objects #(
    parameter logic [15:0] BOOT_MAJOR    = 16'h0000,
    parameter logic [15:0] BOOT_MINOR    = 16'h0000,
    parameter logic [31:0] BOOT_HW_GROUP = 32'h00000000
) (
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire logic [15:0]             obj_index,
    input  wire logic [7:0]              obj_sub,
    input  wire logic                    obj_wr,
    input  wire logic                    obj_rd,
    input  wire logic [31:0]             obj_wdata,
    output logic      [31:0]             obj_rdata,
    output logic                         obj_ack,
    output logic                         obj_err,
    input  wire logic [31:0]             supply_mv,
    input  wire logic [31:0]             logic_mv,
    input  wire logic [31:0]             board_temp_dc,
    input  wire logic [31:0]             fieldbus_avail,
    input  wire logic                    error_log_valid,
    input  wire logic [31:0]             error_log_entry,
    input  wire logic                    fault_event,
    input  wire logic                    fault_present,
    input  wire logic                    warning_event,
    input  wire logic [7:0]              op_mode,
    output logic                         ballast_on,
    output logic                         halt_motion,
    output logic      [2:0]              mode_dependent_bits,
    output logic      [15:0]             status_word,
    output dcobj_pkg::dcobj_pst_e        power_state,
    output logic                         power_stage_enable
);

    ////////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed {
        logic [15:0]           cmd;
        logic [15:0]           err_code;
        logic [31:0]           bal_set;
        logic [31:0]           bal_thr;
        logic [31:0]           bal_hyst;
        logic                  bal_on;
        logic                  halt;
        logic                  fc_prev;
        logic                  warn;
        dcobj_pkg::dcobj_pst_e pst;
        logic [15:0]           status;
        logic [31:0]           rdata;
        logic                  ack;
        logic                  err;
    } dcobj_state_s;

    localparam dcobj_state_s S_RST = '{
        cmd:      dcobj_pkg::CMD_RST,
        err_code: dcobj_pkg::ERR_RST,
        bal_set:  dcobj_pkg::BAL_SET_RST,
        bal_thr:  dcobj_pkg::BAL_THR_RST,
        bal_hyst: dcobj_pkg::BAL_HYST_RST,
        bal_on:   1'b0,
        halt:     1'b0,
        fc_prev:  1'b0,
        warn:     1'b0,
        pst:      dcobj_pkg::PST_NOT_READY,
        status:   16'h0000,
        rdata:    32'h00000000,
        ack:      1'b0,
        err:      1'b0
    };

    dcobj_state_s s;
    dcobj_state_s n;

    // status word image of a power state
    function automatic logic [15:0] dcobj_status_of(input dcobj_pkg::dcobj_pst_e p, input logic w);
        logic [15:0] v;
        v = 16'h0000;
        v[dcobj_pkg::ST_REMOTE] = 1'b1;
        v[dcobj_pkg::ST_WARN]   = w;
        case (p)
            dcobj_pkg::PST_ON_DISABLED: v[dcobj_pkg::ST_ON_DISABLED] = 1'b1;
            dcobj_pkg::PST_READY:
            begin
                v[dcobj_pkg::ST_QUICK_N] = 1'b1;
                v[dcobj_pkg::ST_READY]   = 1'b1;
                v[dcobj_pkg::ST_VOLTAGE] = 1'b1;
            end
            dcobj_pkg::PST_SWITCHED_ON:
            begin
                v[dcobj_pkg::ST_QUICK_N]     = 1'b1;
                v[dcobj_pkg::ST_READY]       = 1'b1;
                v[dcobj_pkg::ST_SWITCHED_ON] = 1'b1;
                v[dcobj_pkg::ST_VOLTAGE]     = 1'b1;
            end
            dcobj_pkg::PST_RUN, dcobj_pkg::PST_QUICK_STOP:
            begin
                v[dcobj_pkg::ST_QUICK_N]     = (p == dcobj_pkg::PST_RUN); // R17
                v[dcobj_pkg::ST_READY]       = 1'b1;
                v[dcobj_pkg::ST_SWITCHED_ON] = 1'b1;
                v[dcobj_pkg::ST_RUN]         = 1'b1;
                v[dcobj_pkg::ST_VOLTAGE]     = 1'b1;
            end
            dcobj_pkg::PST_FAULT_REACT: v[3:0] = 4'hf;
            dcobj_pkg::PST_FAULT:       v[dcobj_pkg::ST_FAULT] = 1'b1;
            default:                    v[3:0] = 4'h0;
        endcase
        return v;
    endfunction : dcobj_status_of

    ////////////////////////////////////////////////////////////////////////
    // ballast comparison in 34-bit signed arithmetic
    logic signed [33:0] sup_w;
    logic signed [33:0] thr_w;
    logic signed [33:0] low_w;
    logic               above_thr;
    logic               below_low;
    logic               fc_rise;
    logic               halt_mode;
    logic               c_so;
    logic               c_ev;
    logic               c_qs;
    logic               c_eo;

    assign sup_w     = {{2{supply_mv[31]}}, supply_mv};
    assign thr_w     = {2'b00, s.bal_thr};
    assign low_w     = thr_w - $signed({2'b00, s.bal_hyst});
    assign above_thr = sup_w > thr_w;
    assign below_low = sup_w < low_w;
    assign fc_rise   = s.cmd[dcobj_pkg::CMD_FAULT_CLEAR] & ~s.fc_prev;
    assign halt_mode = (op_mode == dcobj_pkg::MODE_PROF_POS) || (op_mode == dcobj_pkg::MODE_VELOCITY)
                    || (op_mode == dcobj_pkg::MODE_PROF_VEL) || (op_mode == dcobj_pkg::MODE_PROF_TORQ)
                    || (op_mode == dcobj_pkg::MODE_INTERP);
    assign c_so      = s.cmd[dcobj_pkg::CMD_SWITCH_ON];
    assign c_ev      = s.cmd[dcobj_pkg::CMD_VOLTAGE];
    assign c_qs      = s.cmd[dcobj_pkg::CMD_QUICK_N];
    assign c_eo      = s.cmd[dcobj_pkg::CMD_RUN_PERMIT];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic        hit;
        logic        ro;
        logic [31:0] rv;
        hit = 1'b1;
        ro  = 1'b1;
        rv  = 32'h00000000;
        n   = s;
        n.ack = 1'b0;
        n.err = 1'b0;
        // object decode; write takes priority over read
        case (obj_index)
            dcobj_pkg::IDX_COND:
                case (obj_sub)
                    dcobj_pkg::SUB_0: rv = {24'h000000, dcobj_pkg::COND_COUNT};
                    dcobj_pkg::SUB_1: rv = supply_mv; // R1
                    dcobj_pkg::SUB_2: rv = logic_mv; // R1
                    dcobj_pkg::SUB_3: rv = board_temp_dc; // R1
                    dcobj_pkg::SUB_4, dcobj_pkg::SUB_5: rv = 32'h00000000; // R1
                    default: hit = 1'b0;
                endcase
            dcobj_pkg::IDX_BALLAST:
                case (obj_sub)
                    dcobj_pkg::SUB_0: rv = {24'h000000, dcobj_pkg::BAL_COUNT};
                    dcobj_pkg::SUB_1:
                    begin
                        rv = s.bal_set;
                        ro = 1'b0;
                        if (obj_wr)
                            n.bal_set = obj_wdata; // R2
                    end
                    dcobj_pkg::SUB_2:
                    begin
                        rv = s.bal_thr;
                        ro = 1'b0;
                        if (obj_wr)
                            n.bal_thr = obj_wdata; // R3
                    end
                    dcobj_pkg::SUB_3:
                    begin
                        rv = s.bal_hyst;
                        ro = 1'b0;
                        if (obj_wr)
                            n.bal_hyst = obj_wdata; // R4
                    end
                    default: hit = 1'b0;
                endcase
            dcobj_pkg::IDX_BOOT:
                case (obj_sub)
                    dcobj_pkg::SUB_0: rv = {24'h000000, dcobj_pkg::BOOT_COUNT};
                    dcobj_pkg::SUB_1: rv = {BOOT_MAJOR, BOOT_MINOR}; // R6
                    dcobj_pkg::SUB_2: rv = fieldbus_avail; // R7
                    dcobj_pkg::SUB_3: rv = BOOT_HW_GROUP;
                    default: hit = 1'b0;
                endcase
            dcobj_pkg::IDX_ERR:
                if (obj_sub == dcobj_pkg::SUB_0)
                    rv = {16'h0000, s.err_code};
                else
                    hit = 1'b0;
            dcobj_pkg::IDX_CMD:
                if (obj_sub == dcobj_pkg::SUB_0)
                begin
                    rv = {16'h0000, s.cmd};
                    ro = 1'b0;
                    if (obj_wr)
                        n.cmd = obj_wdata[15:0]; // R10
                end
                else
                    hit = 1'b0;
            dcobj_pkg::IDX_STAT:
                if (obj_sub == dcobj_pkg::SUB_0)
                    rv = {16'h0000, s.status};
                else
                    hit = 1'b0;
            default: hit = 1'b0;
        endcase
        if (obj_wr || obj_rd)
        begin
            n.ack   = 1'b1;
            n.err   = ~hit | (obj_wr & ro); // R1
            n.rdata = (obj_wr || !hit) ? 32'h00000000 : rv;
        end
        // error code and warning; a new event wins over the clear
        n.fc_prev = s.cmd[dcobj_pkg::CMD_FAULT_CLEAR];
        if (fc_rise)
        begin
            n.err_code = 16'h0000; // R9
            n.warn     = 1'b0; // R15
        end
        if (error_log_valid)
            n.err_code = error_log_entry[15:0]; // R8
        if (warning_event)
            n.warn = 1'b1;
        // power state machine
        case (s.pst)
            dcobj_pkg::PST_NOT_READY: n.pst = dcobj_pkg::PST_ON_DISABLED;
            dcobj_pkg::PST_ON_DISABLED:
                if (c_ev && c_qs && !c_so)
                    n.pst = dcobj_pkg::PST_READY; // R12
            dcobj_pkg::PST_READY:
                if (!c_ev || !c_qs)
                    n.pst = dcobj_pkg::PST_ON_DISABLED; // R12
                else if (c_so)
                    n.pst = dcobj_pkg::PST_SWITCHED_ON; // R11
            dcobj_pkg::PST_SWITCHED_ON:
                if (!c_ev || !c_qs)
                    n.pst = dcobj_pkg::PST_ON_DISABLED; // R12
                else if (!c_so)
                    n.pst = dcobj_pkg::PST_READY;
                else if (c_eo)
                    n.pst = dcobj_pkg::PST_RUN; // R14
            dcobj_pkg::PST_RUN:
                if (!c_ev)
                    n.pst = dcobj_pkg::PST_ON_DISABLED; // R12
                else if (!c_qs)
                    n.pst = dcobj_pkg::PST_QUICK_STOP; // R13
                else if (!c_so)
                    n.pst = dcobj_pkg::PST_READY;
                else if (!c_eo)
                    n.pst = dcobj_pkg::PST_SWITCHED_ON;
            dcobj_pkg::PST_QUICK_STOP:
                if (!c_ev)
                    n.pst = dcobj_pkg::PST_ON_DISABLED;
                else if (c_qs && c_so && c_eo)
                    n.pst = dcobj_pkg::PST_RUN; // R14
            dcobj_pkg::PST_FAULT_REACT: n.pst = dcobj_pkg::PST_FAULT;
            dcobj_pkg::PST_FAULT:
                if (fc_rise && !fault_present)
                    n.pst = dcobj_pkg::PST_ON_DISABLED; // R15
            default: n.pst = dcobj_pkg::PST_NOT_READY;
        endcase
        if (fault_event && s.pst != dcobj_pkg::PST_FAULT && s.pst != dcobj_pkg::PST_FAULT_REACT)
            n.pst = dcobj_pkg::PST_FAULT_REACT;
        n.status = dcobj_status_of(n.pst, n.warn); // R17
        // ballast switching with hysteresis
        if (!s.bal_set[dcobj_pkg::BAL_EN_BIT])
            n.bal_on = 1'b0; // R2
        else if (above_thr)
            n.bal_on = 1'b1; // R5
        else if (below_low)
            n.bal_on = 1'b0; // R5
        n.halt = s.cmd[dcobj_pkg::CMD_HALT] & halt_mode; // R16
    end

    // state register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            s <= S_RST;
        else
            s <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign obj_rdata           = s.rdata;
    assign obj_ack             = s.ack;
    assign obj_err             = s.err;
    assign ballast_on          = s.bal_on;
    assign halt_motion         = s.halt;
    assign mode_dependent_bits = s.cmd[dcobj_pkg::CMD_MODE_HI:dcobj_pkg::CMD_MODE_LO];
    assign status_word         = s.status;
    assign power_state         = s.pst;
    assign power_stage_enable  = (s.pst == dcobj_pkg::PST_SWITCHED_ON) || (s.pst == dcobj_pkg::PST_RUN)
                              || (s.pst == dcobj_pkg::PST_QUICK_STOP);

    ////////////////////////////////////////////////////////////////////////
    // assertions
    AST_COND_RO: assert property (@(posedge clock) disable iff (rst) // R1
        obj_wr && obj_index == dcobj_pkg::IDX_COND |=> obj_ack && obj_err)
        else $error("write to operating conditions not refused");
    AST_BAL_OFF: assert property (@(posedge clock) disable iff (rst) // R2
        !s.bal_set[0] |=> !ballast_on)
        else $error("ballast on while disabled");
    AST_THR_WR: assert property (@(posedge clock) disable iff (rst) // R3
        obj_wr && obj_index == dcobj_pkg::IDX_BALLAST && obj_sub == dcobj_pkg::SUB_2
        |=> s.bal_thr == $past(obj_wdata))
        else $error("threshold write lost");
    AST_HYST_WR: assert property (@(posedge clock) disable iff (rst) // R4
        obj_wr && obj_index == dcobj_pkg::IDX_BALLAST && obj_sub == dcobj_pkg::SUB_3
        |=> s.bal_hyst == $past(obj_wdata))
        else $error("hysteresis write lost");
    AST_BAL_HOLD: assert property (@(posedge clock) disable iff (rst) // R5
        s.bal_set[0] && !above_thr && !below_low |=> ballast_on == $past(ballast_on))
        else $error("ballast changed inside hysteresis band");
    AST_BAL_ON: assert property (@(posedge clock) disable iff (rst) // R5
        s.bal_set[0] && above_thr |=> ballast_on)
        else $error("ballast not on above threshold");
    AST_BOOT_VER: assert property (@(posedge clock) disable iff (rst) // R6
        obj_rd && !obj_wr && obj_index == dcobj_pkg::IDX_BOOT && obj_sub == dcobj_pkg::SUB_1
        |=> obj_rdata == {BOOT_MAJOR, BOOT_MINOR})
        else $error("boot version read wrong");
    AST_ERR_LOG: assert property (@(posedge clock) disable iff (rst) // R8
        error_log_valid |=> s.err_code == $past(error_log_entry[15:0]))
        else $error("error code not taken from log");
    AST_ERR_CLR: assert property (@(posedge clock) disable iff (rst) // R9
        fc_rise && !error_log_valid |=> s.err_code == 16'h0000)
        else $error("error code not cleared by fault clear");
    AST_SWITCH_ON: assert property (@(posedge clock) disable iff (rst) // R11
        s.pst == dcobj_pkg::PST_READY && c_ev && c_qs && c_so && !fault_event
        |=> power_state == dcobj_pkg::PST_SWITCHED_ON)
        else $error("switch on not honoured");
    AST_QUICK: assert property (@(posedge clock) disable iff (rst) // R13
        s.pst == dcobj_pkg::PST_RUN && c_ev && !c_qs && !fault_event
        |=> power_state == dcobj_pkg::PST_QUICK_STOP && !status_word[dcobj_pkg::ST_QUICK_N])
        else $error("quick stop not entered");
    AST_HALT: assert property (@(posedge clock) disable iff (rst) // R16
        s.cmd[dcobj_pkg::CMD_HALT] && !halt_mode |=> !halt_motion)
        else $error("halt outside permitted mode");
    AST_QS_STATUS: assert property (@(posedge clock) disable iff (rst) // R17
        power_state == dcobj_pkg::PST_QUICK_STOP |-> !status_word[5] && status_word[2])
        else $error("quick stop status bit wrong");

endmodule : dcobj_drive_objects

// *** dcobj_master.sv ***
// fieldbus master model: issues single object accesses, one request pulse each.
// assumes the device answers one edge after it takes a request.
module dcobj_master (
    input  wire logic        clock,
    output logic      [15:0] obj_index,
    output logic      [7:0]  obj_sub,
    output logic             obj_wr,
    output logic             obj_rd,
    output logic      [31:0] obj_wdata,
    input  wire logic [31:0] obj_rdata,
    input  wire logic        obj_ack,
    input  wire logic        obj_err
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial
    begin
        obj_wr    = 1'h0;
        obj_rd    = 1'h0;
        obj_index = 16'h0000;
        obj_sub   = 8'h00;
        obj_wdata = 32'h00000000;
    end

    // one access: pulse at an edge, answer sampled mid-cycle after the next edge
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok, output logic er);
        @(posedge clock);
        obj_wr    <= wr;
        obj_rd    <= ~wr;
        obj_index <= idx;
        obj_sub   <= sub;
        obj_wdata <= wd;
        @(posedge clock);
        obj_wr    <= 1'h0;
        obj_rd    <= 1'h0;
        obj_index <= ~idx; // released lines carry no stale value
        obj_sub   <= ~sub;
        obj_wdata <= ~wd;
        @(negedge clock);
        ok = obj_ack;
        er = obj_err;
        rd = obj_rdata;
    endtask : access
endmodule : dcobj_master

// *** drive_control_objects_bench.sv ***
// testbench for the drive control objects: map, ballast, error code, command word.
// assumes dcobj_master as the fieldbus side; runs from one 20 MHz clock.
module drive_control_objects_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clock = 1'h0;
    logic                  rst   = 1'h1;
    logic [15:0]           obj_index;
    logic [7:0]            obj_sub, op_mode = 8'h00;
    logic                  obj_wr, obj_rd, obj_ack, obj_err, ok_v, er_v;
    logic [31:0]           obj_wdata, obj_rdata, rd_v;
    logic [31:0]           supply_mv = 32'h0, logic_mv = 32'h1388, temp_dc = 32'hfa;
    logic [31:0]           avail = 32'h5, log_entry = 32'h0;
    logic                  log_valid = 1'h0, f_event = 1'h0, f_present = 1'h0, w_event = 1'h0;
    logic                  ballast_on, halt_motion, stage_en;
    logic [2:0]            mode_bits;
    logic [15:0]           status_word;
    dcobj_pkg::dcobj_pst_e power_state;
    int                    err_total = 0, n_checks = 0;

    // 50 ns clock
    always #25 clock = ~clock;

    dcobj_master m (.clock(clock), .obj_index(obj_index), .obj_sub(obj_sub), .obj_wr(obj_wr),
        .obj_rd(obj_rd), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err));
    dcobj_drive_objects #(.BOOT_MAJOR(16'h0004), .BOOT_MINOR(16'h0002)) uut (.clock(clock), .rst(rst),
        .obj_index(obj_index), .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_wdata(obj_wdata),
        .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err), .supply_mv(supply_mv),
        .logic_mv(logic_mv), .board_temp_dc(temp_dc), .fieldbus_avail(avail), .error_log_valid(log_valid),
        .error_log_entry(log_entry), .fault_event(f_event), .fault_present(f_present),
        .warning_event(w_event), .op_mode(op_mode), .ballast_on(ballast_on), .halt_motion(halt_motion),
        .mode_dependent_bits(mode_bits), .status_word(status_word), .power_state(power_state),
        .power_stage_enable(stage_en));

    ////////////////////////////////////////////////////////////////////////
    // compare, count, report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one access with expected abort flag and read data
    task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                       input logic [31:0] exp, input logic e);
        m.access(w, i, s, d, rd_v, ok_v, er_v);
        chk("ack", {31'h0, ok_v}, 32'h1);
        chk("abort", {31'h0, er_v}, {31'h0, e});
        chk("data", rd_v, exp);
    endtask : acc

    // let inputs and registered outputs settle
    task automatic settle;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask : settle

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [15:0] ri [17] = '{16'h4021, 16'h4021, 16'h4021, 16'h4021, 16'h603f, 16'h6040, 16'h4014,
            16'h4014, 16'h4014, 16'h4014, 16'h4014, 16'h4014, 16'h4042, 16'h4042, 16'h4042, 16'h1234, 16'h4021};
        logic [7:0]  rs [17] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h0, 8'h0, 8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5,
            8'h0, 8'h1, 8'h2, 8'h0, 8'h4};
        logic [31:0] rv [17] = '{32'h3, 32'h1, 32'hc019, 32'h1f4, 32'h0, 32'h0, 32'h5, 32'h0, 32'h1388,
            32'hfa, 32'h0, 32'h0, 32'h3, 32'h00040002, 32'h5, 32'h0, 32'h0};
        logic [15:0] wi [5]  = '{16'h4014, 16'h603f, 16'h4042, 16'h6041, 16'h4021};
        logic [31:0] sv [5]  = '{32'd1001, 32'd900, 32'd899, 32'd1000, 32'd1001};
        logic [15:0] cw [7]  = '{16'h6, 16'h7, 16'hf, 16'hb, 16'hf, 16'h7, 16'h0};
        logic [15:0] sw [7]  = '{16'h231, 16'h233, 16'h237, 16'h217, 16'h237, 16'h233, 16'h240};
        dcobj_pkg::dcobj_pst_e ps [7] = '{dcobj_pkg::PST_READY, dcobj_pkg::PST_SWITCHED_ON,
            dcobj_pkg::PST_RUN, dcobj_pkg::PST_QUICK_STOP, dcobj_pkg::PST_RUN,
            dcobj_pkg::PST_SWITCHED_ON, dcobj_pkg::PST_ON_DISABLED};
        repeat (12) @(posedge clock);
        rst <= 1'h0;
        settle();
        for (int k = 0; k < 17; k++) acc(1'h0, ri[k], rs[k], 32'h0, rv[k], k > 14);
        for (int k = 0; k < 5; k++) acc(1'h1, wi[k], 8'h0 + (k == 0 || k == 2), 32'h7, 32'h0, 1'h1);
        acc(1'h0, 16'h603f, 8'h0, 32'h0, 32'h0, 1'h0);
        acc(1'h1, 16'h4021, 8'h2, 32'h3e8, 32'h0, 1'h0);
        acc(1'h1, 16'h4021, 8'h3, 32'h64, 32'h0, 1'h0);
        acc(1'h0, 16'h4021, 8'h3, 32'h0, 32'h64, 1'h0);
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clock) supply_mv <= sv[k];
            settle();
            chk("ballast", {31'h0, ballast_on}, {31'h0, k != 2 && k != 3});
        end
        acc(1'h1, 16'h4021, 8'h1, 32'h0, 32'h0, 1'h0);
        settle();
        chk("ballast off", {31'h0, ballast_on}, 32'h0);
        for (int k = 0; k < 7; k++)
        begin
            acc(1'h1, 16'h6040, 8'h0, {16'h0, cw[k]}, 32'h0, 1'h0);
            settle();
            chk("state", {29'h0, power_state}, {29'h0, ps[k]});
            chk("status", {16'h0, status_word & 16'h027f}, {16'h0, sw[k]});
            chk("stage", {31'h0, stage_en}, {31'h0, k inside {[1:5]}});
        end
        @(posedge clock);
        log_valid <= 1'h1;
        f_event   <= 1'h1;
        f_present <= 1'h1;
        log_entry <= 32'h5555abcd;
        @(posedge clock);
        log_valid <= 1'h0;
        f_event   <= 1'h0;
        settle();
        chk("fault", {29'h0, power_state}, {29'h0, dcobj_pkg::PST_FAULT});
        acc(1'h0, 16'h603f, 8'h0, 32'h0, 32'habcd, 1'h0);
        acc(1'h1, 16'h6040, 8'h0, 32'h80, 32'h0, 1'h0);
        settle();
        acc(1'h0, 16'h603f, 8'h0, 32'h0, 32'h0, 1'h0);
        chk("fault held", {29'h0, power_state}, {29'h0, dcobj_pkg::PST_FAULT});
        @(posedge clock) f_present <= 1'h0;
        acc(1'h1, 16'h6040, 8'h0, 32'h0, 32'h0, 1'h0);
        acc(1'h1, 16'h6040, 8'h0, 32'h80, 32'h0, 1'h0);
        settle();
        chk("fault cleared", {29'h0, power_state}, {29'h0, dcobj_pkg::PST_ON_DISABLED});
        acc(1'h1, 16'h6040, 8'h0, 32'habcd0170, 32'h0, 1'h0);
        acc(1'h0, 16'h6040, 8'h0, 32'h0, 32'h170, 1'h0);
        chk("mode bits", {29'h0, mode_bits}, 32'h7);
        for (int k = 0; k < 9; k++)
        begin
            @(posedge clock) op_mode <= k[7:0];
            settle();
            chk("halt", {31'h0, halt_motion}, {31'h0, k inside {1, 2, 3, 4, 7}});
        end
        end_of_test();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        end_of_test();
    end
endmodule : drive_control_objects_bench
